//--- common/sltp_pkg.sv
// Constants shared by the serial link test pattern generator.
package sltp_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
  localparam logic [11:0] ADDR_USER_BASE = 12'h551;
  localparam logic [11:0] ADDR_USER_LAST = 12'h558;
  localparam logic [11:0] ADDR_SYNC_CTRL = 12'h572;
  localparam logic [11:0] ADDR_TEST_SEL = 12'h573;
  localparam logic [11:0] ADDR_LINK_TEST = 12'h574;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h81;
  localparam logic [7:0] SYNC_DISABLE = 8'hC0;

  // ---------------------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] TEST_SEL_RST = 8'h00;
  localparam logic [7:0] LINK_TEST_RST = 8'h00;
  localparam logic [7:0] USER_RST = 8'h00;
  localparam int unsigned CODE_LSB = 0;
  localparam int unsigned POINT_LSB = 4;
  localparam int unsigned LINK_TEST_W = 3;
  localparam int unsigned USER_BYTES = 8;

  // ---------------------------------------------------------------------------
  // Injection points and pattern codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] POINT_SAMPLE = 2'h0;
  localparam logic [1:0] POINT_SYMBOL = 2'h1;
  localparam logic [1:0] POINT_OCTET = 2'h2;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_CHECKER = 4'h1;
  localparam logic [3:0] CODE_TOGGLE = 4'h2;
  localparam logic [3:0] CODE_PN23 = 4'h4;
  localparam logic [3:0] CODE_PN9 = 4'h6;
  localparam logic [3:0] CODE_RAMP = 4'h8;
  localparam logic [3:0] CODE_USER_REPEAT = 4'hE;
  localparam logic [3:0] CODE_USER_SINGLE = 4'hF;

  // ---------------------------------------------------------------------------
  // Pattern values and word widths
  // ---------------------------------------------------------------------------
  localparam logic [15:0] CHECKER_EVEN = 16'h5555;
  localparam logic [15:0] CHECKER_ODD = 16'hAAAA;
  localparam logic [15:0] TOGGLE_EVEN = 16'h0000;
  localparam logic [15:0] TOGGLE_ODD = 16'hFFFF;
  localparam logic [15:0] MASK_SAMPLE = 16'hFFFF;
  localparam logic [15:0] MASK_SYMBOL = 16'h03FF;
  localparam logic [15:0] MASK_OCTET = 16'h00FF;
  localparam logic [4:0] NBITS_SAMPLE = 5'h10;
  localparam logic [4:0] NBITS_SYMBOL = 5'h0A;
  localparam logic [4:0] NBITS_OCTET = 5'h08;
  localparam int unsigned USER_SYMBOL_LSB = 6;
  localparam int unsigned USER_OCTET_LSB = 9;

  // ---------------------------------------------------------------------------
  // Pseudo-random generators (seed holds the first stream bits, MSB first)
  // ---------------------------------------------------------------------------
  localparam int unsigned PN9_LEN = 9;
  localparam int unsigned PN9_TAP = 4;
  localparam logic [8:0] PN9_SEED = 9'h092;
  localparam int unsigned PN23_LEN = 23;
  localparam int unsigned PN23_TAP = 17;
  localparam logic [22:0] PN23_SEED = 23'h7FAE00;
  localparam logic [15:0] PN9_FIRST_SAMPLE = 16'h496F;
  localparam logic [15:0] PN23_FIRST_SAMPLE = 16'hFF5C;

endpackage

//--- logic/sltp_prbs.sv
// Bit-serial pseudo-random generator that steps a chosen number of bits at a time.
`timescale 1ns/1ps
`default_nettype none

module sltp_prbs #(
  parameter int unsigned LEN = 9,
  parameter int unsigned TAP = 4,
  parameter logic [LEN-1:0] SEED = '1
) (
  input wire logic mclk_i,        // Converter clock.
  input wire logic reset_n_i,     // Synchronous reset, active low.
  input wire logic ce_i,          // Clock enable.
  input wire logic restart_i,     // Return to the seed.
  input wire logic adv_i,         // Advance by nbits_i bits.
  input wire logic [4:0] nbits_i, // Bits consumed per word.
  output logic [15:0] bits_o      // Next 16 stream bits, first bit in bit 15.
);

  if (LEN < 2 || TAP >= LEN - 1) begin : g_bad_poly
    $error("sltp_prbs: tap must lie below the last stage");
  end

  logic [LEN-1:0] state_reg;
  logic [LEN-1:0] state_next;

  function automatic logic [LEN-1:0] shift_one(input logic [LEN-1:0] s);
    return {s[LEN-2:0], s[LEN-1] ^ s[TAP]};
  endfunction

  always_comb begin
    logic [LEN-1:0] s;
    s = state_reg;
    bits_o = '0;
    state_next = state_reg;
    for (int i = 0; i < 16; i++) begin
      bits_o[15-i] = s[LEN-1];
      s = shift_one(s);
      if (5'(i + 1) == nbits_i) begin
        state_next = s;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_reg <= SEED;
    end else if (ce_i) begin
      if (restart_i) begin
        state_reg <= SEED;
      end else if (adv_i) begin
        state_reg <= state_next;
      end
    end
  end

endmodule // sltp_prbs

`default_nettype wire

//--- logic/sltp_pattern_gen.sv
// Test pattern generator and its byte-wide control registers for the serial link.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Code 00 injects 16-bit transport samples.
// - Code 01 injects 10-bit encoded symbols.
// - Code 10 injects 8-bit scrambler octets.
// - Sample point: one value per frame.
// - Sample checker, toggle, PN9, PN23 values fixed.
// - Symbol point: 10-bit values, user bits 15:6.
// - Octet point: 8-bit values, user bits 15:9.
// - Ramp counts up, wraps at word width.
// - User repeat cycles; single sends then zeros.
// - Link layer test select in bits 2:0.
// - All registers byte-wide and writable; all but soft reset read back, soft reset reads zero.
// - Pattern code bits 3:0, 0000 is normal.
module sltp_pattern_gen (
  input wire logic mclk_i,                              // Converter clock.
  input wire logic reset_n_i,                           // Synchronous reset, active low.
  input wire logic ce_i,                                // Clock enable, freezes all state.
  input wire logic [sltp_pkg::ADDR_W-1:0] reg_addr_i,   // Register address.
  input wire logic reg_wr_i,                            // Write strobe.
  input wire logic reg_rd_i,                            // Read strobe.
  input wire logic [7:0] reg_wdata_i,                   // Write data.
  output logic [7:0] reg_rdata_o,                       // Read data.
  output logic reg_rvalid_o,                            // Read data valid.
  input wire logic step_i,                              // Current word consumed by the link.
  output logic [15:0] pattern_o,                        // Current test word, low aligned.
  output logic inject_sample_o,                         // Replace transport samples.
  output logic inject_symbol_o,                         // Replace 10-bit symbols.
  output logic inject_octet_o,                          // Replace scrambler octets.
  output logic [sltp_pkg::LINK_TEST_W-1:0] link_test_o, // Link layer test select.
  output logic sync_request_enable_o                    // Sync request input honoured.
);
  import sltp_pkg::*;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] sync_ctrl_reg;
  logic [7:0] test_sel_reg;
  logic [7:0] link_test_reg;
  logic [7:0] user_reg [USER_BYTES];
  logic [7:0] rdata_reg;
  logic rvalid_reg;

  logic wr_en;
  logic soft_rst;
  logic wr_test;
  logic restart;
  logic user_hit;
  logic [2:0] user_off;
  logic [11:0] user_delta;
  logic [7:0] rd_mux;

  assign wr_en = ce_i & reg_wr_i;
  assign soft_rst = wr_en & (reg_addr_i == ADDR_SOFT_RESET) & (reg_wdata_i == SOFT_RESET_CMD);
  assign wr_test = wr_en & (reg_addr_i == ADDR_TEST_SEL);
  assign restart = wr_test | soft_rst;
  assign user_delta = reg_addr_i - ADDR_USER_BASE;
  assign user_off = user_delta[2:0];
  assign user_hit = (reg_addr_i >= ADDR_USER_BASE) && (reg_addr_i <= ADDR_USER_LAST);

  // Unmapped addresses and the self-clearing soft reset location read as zero.
  assign rd_mux = (reg_addr_i == ADDR_SYNC_CTRL) ? sync_ctrl_reg :
                  (reg_addr_i == ADDR_TEST_SEL) ? test_sel_reg :
                  (reg_addr_i == ADDR_LINK_TEST) ? link_test_reg :
                  user_hit ? user_reg[user_off] : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || (ce_i && soft_rst)) begin
      sync_ctrl_reg <= SYNC_CTRL_RST;
      test_sel_reg <= TEST_SEL_RST;
      link_test_reg <= LINK_TEST_RST;
      for (int i = 0; i < USER_BYTES; i++) begin
        user_reg[i] <= USER_RST;
      end
    end else if (wr_en) begin
      if (reg_addr_i == ADDR_SYNC_CTRL) sync_ctrl_reg <= reg_wdata_i;
      if (wr_test) test_sel_reg <= reg_wdata_i;
      if (reg_addr_i == ADDR_LINK_TEST) link_test_reg <= reg_wdata_i;
      if (user_hit) user_reg[user_off] <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else if (ce_i) begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign link_test_o = link_test_reg[LINK_TEST_W-1:0];
  assign sync_request_enable_o = (sync_ctrl_reg & SYNC_DISABLE) != SYNC_DISABLE;

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  logic [3:0] code;
  logic [1:0] point;
  logic active;
  logic [15:0] mask;
  logic [4:0] nbits;

  assign code = test_sel_reg[CODE_LSB+:4];
  assign point = test_sel_reg[POINT_LSB+:2];
  assign active = (code != CODE_OFF) && (point != 2'h3);
  assign inject_sample_o = active && (point == POINT_SAMPLE);
  assign inject_symbol_o = active && (point == POINT_SYMBOL);
  assign inject_octet_o = active && (point == POINT_OCTET);
  assign mask = (point == POINT_SAMPLE) ? MASK_SAMPLE :
                (point == POINT_SYMBOL) ? MASK_SYMBOL : MASK_OCTET;
  assign nbits = (point == POINT_SAMPLE) ? NBITS_SAMPLE :
                 (point == POINT_SYMBOL) ? NBITS_SYMBOL : NBITS_OCTET;

  // User words sit low byte first; narrow points take the top bits of each word.
  function automatic logic [15:0] user_slice(input logic [15:0] w, input logic [1:0] p);
    if (p == POINT_SYMBOL) return w >> USER_SYMBOL_LSB;
    if (p == POINT_OCTET) return w >> USER_OCTET_LSB;
    return w;
  endfunction

  // ---------------------------------------------------------------------------
  // Pattern sequencing
  // ---------------------------------------------------------------------------
  logic prime_reg;
  logic phase_reg;
  logic [15:0] ramp_reg;
  logic [1:0] user_idx_reg;
  logic user_done_reg;
  logic [15:0] pattern_reg;
  logic load;
  logic [15:0] pn9_bits;
  logic [15:0] pn23_bits;
  logic [4:0] shamt;
  logic [15:0] user_word;
  logic [15:0] word_next;

  // The prime load fills the first word after a restart; later words follow the link.
  assign load = ce_i & ~restart & (prime_reg | (step_i & active));
  assign shamt = 5'h10 - nbits;
  assign user_word = {user_reg[{user_idx_reg, 1'b1}], user_reg[{user_idx_reg, 1'b0}]};

  sltp_prbs #(.LEN(PN9_LEN), .TAP(PN9_TAP), .SEED(PN9_SEED)) u_pn9 (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .restart_i(restart),
    .adv_i(load && (code == CODE_PN9)),
    .nbits_i(nbits),
    .bits_o(pn9_bits)
  );

  sltp_prbs #(.LEN(PN23_LEN), .TAP(PN23_TAP), .SEED(PN23_SEED)) u_pn23 (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .restart_i(restart),
    .adv_i(load && (code == CODE_PN23)),
    .nbits_i(nbits),
    .bits_o(pn23_bits)
  );

  always_comb begin
    case (code)
      CODE_CHECKER: word_next = (phase_reg ? CHECKER_ODD : CHECKER_EVEN) & mask;
      CODE_TOGGLE: word_next = (phase_reg ? TOGGLE_ODD : TOGGLE_EVEN) & mask;
      CODE_PN9: word_next = pn9_bits >> shamt;
      CODE_PN23: word_next = pn23_bits >> shamt;
      CODE_RAMP: word_next = ramp_reg & mask;
      CODE_USER_REPEAT: word_next = user_slice(user_word, point);
      CODE_USER_SINGLE: word_next = user_done_reg ? 16'h0000 : user_slice(user_word, point);
      default: word_next = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || (ce_i && restart)) begin
      prime_reg <= reset_n_i;
      phase_reg <= 1'b0;
      ramp_reg <= 16'h0000;
      user_idx_reg <= 2'h0;
      user_done_reg <= 1'b0;
      pattern_reg <= 16'h0000;
    end else if (load) begin
      prime_reg <= 1'b0;
      pattern_reg <= active ? word_next : 16'h0000;
      phase_reg <= ~phase_reg;
      ramp_reg <= ramp_reg + 16'h0001;
      user_idx_reg <= user_idx_reg + 2'h1;
      if (user_idx_reg == 2'h3) user_done_reg <= 1'b1;
    end
  end

  assign pattern_o = pattern_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [2:0] loads_seen_reg;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || (ce_i && restart)) begin
      loads_seen_reg <= 3'h0;
    end else if (load && loads_seen_reg != 3'h7) begin
      loads_seen_reg <= loads_seen_reg + 3'h1;
    end
  end

  AST_SAMPLE_POINT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && inject_sample_o && code == CODE_TOGGLE)
      |=> (pattern_o == TOGGLE_EVEN || pattern_o == TOGGLE_ODD))
    else $error("sample word not full width");

  AST_SYMBOL_WIDTH: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && inject_symbol_o) |=> (pattern_o[15:10] == 6'h00))
    else $error("symbol word wider than ten bits");

  AST_OCTET_WIDTH: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && inject_octet_o) |=> (pattern_o[15:8] == 8'h00))
    else $error("octet word wider than eight bits");

  AST_FRAME_HOLD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!load && !restart) |=> $stable(pattern_o))
    else $error("pattern changed without a step");

  AST_PN9_START: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && prime_reg && code == CODE_PN9 && point == POINT_SAMPLE)
      |=> (pattern_o == PN9_FIRST_SAMPLE))
    else $error("PN9 does not start from its seed");

  AST_PN23_START: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && prime_reg && code == CODE_PN23 && point == POINT_SAMPLE)
      |=> (pattern_o == PN23_FIRST_SAMPLE))
    else $error("PN23 does not start from its seed");

  AST_CHECKER_ALT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && !prime_reg && code == CODE_CHECKER && point == POINT_SYMBOL)
      |=> (pattern_o == ($past(pattern_o) ^ MASK_SYMBOL)))
    else $error("checkerboard did not alternate");

  AST_RAMP_STEP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && !prime_reg && active && code == CODE_RAMP)
      |=> (pattern_o == (($past(pattern_o) + 16'h0001) & $past(mask))))
    else $error("ramp did not advance by one");

  AST_USER_SINGLE_ZERO: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (load && code == CODE_USER_SINGLE && loads_seen_reg >= 3'h4) |=> (pattern_o == 16'h0000))
    else $error("single user pattern did not end in zeros");

  AST_OFF_NO_INJECT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (code == CODE_OFF)
      |-> (!(inject_sample_o || inject_symbol_o || inject_octet_o) && pattern_o == 16'h0000))
    else $error("injection while pattern code is off");

  AST_READ_BACK: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && reg_rd_i && reg_addr_i == ADDR_TEST_SEL) |=> (reg_rvalid_o && reg_rdata_o == test_sel_reg))
    else $error("read back differs from register");

  AST_RESTART_PRIME: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (ce_i && restart) |=> (prime_reg && pattern_o == 16'h0000))
    else $error("restart did not rearm the generators");

endmodule // sltp_pattern_gen

`default_nettype wire

//--- sim/sltp_link_rx_model.sv
// Link-side consumer model that takes pattern words and records the first few.
`timescale 1ns/1ps
`default_nettype none

module sltp_link_rx_model (
  input wire logic mclk_i,           // Converter clock.
  input wire logic reset_n_i,        // Synchronous reset, active low.
  input wire logic run_i,            // Consume words while high.
  input wire logic slow_i,           // Consume one word every fourth cycle.
  input wire logic [15:0] pattern_i, // Word offered by the generator.
  output logic step_o,               // Word consumed this cycle.
  output logic [15:0] cnt_o,         // Words consumed since run rose.
  output logic [15:0] seen_o [6]     // First words consumed.
);
  logic run_q;
  logic [1:0] div;

  // The count restarts on each new run so the bench can relate it to the ramp.
  always_ff @(posedge mclk_i) begin
    run_q <= run_i;
    if (!reset_n_i || !run_i) begin
      step_o <= 1'b0;
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
      step_o <= !slow_i || (div == 2'h3);
    end
    if (!reset_n_i || (run_i && !run_q)) begin
      cnt_o <= 16'h0000;
    end else if (step_o) begin
      cnt_o <= cnt_o + 16'h0001;
      if (cnt_o < 16'h0006) begin
        seen_o[cnt_o[2:0]] <= pattern_i;
      end
    end
  end
endmodule // sltp_link_rx_model
`default_nettype wire

//--- sim/test_serial_link_test_pattern_gen.sv
// Self-checking bench for the serial link test pattern generator.
`timescale 1ns/1ps
`default_nettype none

module test_serial_link_test_pattern_gen;
  import sltp_pkg::*;
  logic mclk_i, reset_n_i, ce_i, reg_wr_i, reg_rd_i, reg_rvalid_o, step;
  logic [11:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] pattern_o, cnt;
  logic [15:0] seen [6];
  logic inject_sample_o, inject_symbol_o, inject_octet_o, sync_request_enable_o;
  logic [2:0] link_test_o;
  logic rx_run, rx_slow;
  logic [71:0] row;
  int fail_count, checks_done;
  logic [15:0] up [4] = '{16'hA5C3, 16'h1234, 16'hFEDC, 16'h8001};
  // Each row: select byte, then the first four words consumed.
  localparam logic [71:0] ROWS [20] = '{
    72'h01_5555_AAAA_5555_AAAA, 72'h02_0000_FFFF_0000_FFFF, 72'h04_FF5C_0029_B80A_3D72,
    72'h06_496F_C9A9_980C_651A, 72'h08_0000_0001_0002_0003, 72'h0E_A5C3_1234_FEDC_8001,
    72'h0F_A5C3_1234_FEDC_8001, 72'h11_0155_02AA_0155_02AA, 72'h12_0000_03FF_0000_03FF,
    72'h14_03FD_01C0_000A_01B8, 72'h16_0125_02FC_026A_0198, 72'h18_0000_0001_0002_0003,
    72'h1E_0297_0048_03FB_0200, 72'h21_0055_00AA_0055_00AA, 72'h22_0000_00FF_0000_00FF,
    72'h24_00FF_005C_0000_0029, 72'h26_0049_006F_00C9_00A9, 72'h28_0000_0001_0002_0003,
    72'h2F_0052_0009_007F_0040, 72'h03_0000_0000_0000_0000};

  sltp_pattern_gen sltp_pattern_gen_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .step_i(step), .pattern_o(pattern_o), .inject_sample_o(inject_sample_o),
    .inject_symbol_o(inject_symbol_o), .inject_octet_o(inject_octet_o),
    .link_test_o(link_test_o), .sync_request_enable_o(sync_request_enable_o));

  sltp_link_rx_model sltp_link_rx_model_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .run_i(rx_run), .slow_i(rx_slow), .pattern_i(pattern_o), .step_o(step), .cnt_o(cnt),
    .seen_o(seen));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({15'h0000, reg_rvalid_o}, 16'h0001);
    chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    reg_addr_i = 12'h000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    rx_run = 1'b0;
    rx_slow = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(ADDR_SYNC_CTRL, SYNC_CTRL_RST);
    rd(ADDR_TEST_SEL, TEST_SEL_RST);
    rd(ADDR_LINK_TEST, LINK_TEST_RST);
    chk({12'h000, sync_request_enable_o, link_test_o}, 16'h0008);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_USER_BASE + 12'(2 * k), up[k][7:0]);
      wr(ADDR_USER_BASE + 12'(2 * k + 1), up[k][15:8]);
    end
    rd(ADDR_USER_LAST, 8'h80);
    wr(12'h575, 8'h5A);
    rd(12'h575, 8'h00);
    for (int i = 0; i < 20; i++) begin
      row = ROWS[i];
      wr(ADDR_TEST_SEL, row[71:64]);
      rx_slow <= i[0];
      rx_run <= 1'b1;
      repeat (30) @(posedge mclk_i);
      rx_run <= 1'b0;
      rd(ADDR_TEST_SEL, row[71:64]);
      chk({13'h0000, inject_octet_o, inject_symbol_o, inject_sample_o},
          16'h0001 << row[69:68]);
      for (int j = 0; j < 4; j++) begin
        chk(seen[j], row[63 - 16 * j -: 16]);
      end
      if (row[67:64] == CODE_USER_SINGLE) chk(seen[4], 16'h0000);
      else if (row[67:64] inside {CODE_CHECKER, CODE_TOGGLE, CODE_USER_REPEAT})
        chk(seen[4], row[63:48]);
    end
    for (int p = 1; p < 3; p++) begin
      wr(ADDR_TEST_SEL, {2'h0, p[1:0], CODE_RAMP});
      rx_slow <= 1'b0;
      rx_run <= 1'b1;
      repeat (1100) @(posedge mclk_i);
      rx_run <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      chk(pattern_o, cnt & ((p == 1) ? MASK_SYMBOL : MASK_OCTET));
    end
    wr(ADDR_SYNC_CTRL, SYNC_DISABLE);
    rd(ADDR_SYNC_CTRL, SYNC_DISABLE);
    chk({15'h0000, sync_request_enable_o}, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_LINK_TEST, 8'(m));
      rd(ADDR_LINK_TEST, 8'(m));
      chk({13'h0000, link_test_o}, 16'(m));
    end
    // A write while the clock enable is low must leave the register untouched.
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(ADDR_LINK_TEST, 8'h00);
    ce_i <= 1'b1;
    rd(ADDR_LINK_TEST, 8'h07);
    wr(ADDR_SOFT_RESET, SOFT_RESET_CMD);
    wr(ADDR_TEST_SEL, 8'h10);
    rd(ADDR_TEST_SEL, 8'h10);
    chk({13'h0000, inject_octet_o, inject_symbol_o, inject_sample_o}, 16'h0000);
    wr(ADDR_TEST_SEL, 8'h31);
    rd(ADDR_TEST_SEL, 8'h31);
    chk({13'h0000, inject_octet_o, inject_symbol_o, inject_sample_o}, 16'h0000);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(ADDR_TEST_SEL, 8'h00);
    wr(ADDR_TEST_SEL, 8'h21);
    wr(ADDR_SYNC_CTRL, SYNC_DISABLE);
    wr(ADDR_LINK_TEST, 8'h03);
    wr(ADDR_SOFT_RESET, SOFT_RESET_CMD);
    rd(ADDR_SOFT_RESET, 8'h00);
    rd(ADDR_LINK_TEST, 8'h00);
    chk({12'h000, sync_request_enable_o, inject_octet_o, inject_symbol_o, inject_sample_o},
        16'h0008);
    test_done();
  end
endmodule // test_serial_link_test_pattern_gen
`default_nettype wire
